/* File: design/dsf_frame.sv */
/*
 File holds the serial frame receiver with readback and output update timing.
 Assumes serial pins already synchronous to ref_clk; the host keeps its own gaps.
*/
`default_nettype none
module dsf_frame
   import dsf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic frame_sync_n,
   input wire logic sdi,
   input wire logic load_dac_n,
   input wire logic crc_en,
   input wire logic slew_en,
   input wire logic autostatus_en,
   input wire logic [23:0] status_word,
   output logic sdo,
   output logic [15:0] dac_out,
   output logic out_update,
   output logic frame_done,
   output logic [23:0] frame_data
);
   // Elaboration checks: both countdowns must fit the delay counter and their limits.
   if (UPDATE_LAT_CYC < 1 || UPDATE_LAT_CYC > LOAD_FAST_CYC) begin : g_lat_chk
      $error("Update latency out of range.");
   end
   if (LOAD_SLEW_CYC < 3 || LOAD_SLEW_CYC > 257) begin : g_slew_chk
      $error("Slew wait does not fit the delay counter.");
   end

   // -----------------------------------------------------------------
   // Serial receive
   // -----------------------------------------------------------------
   logic sclk_q, sclk_d, fs_q, fs_d, ld_q, ld_d;
   logic [5:0] cnt_q, cnt_d;
   logic [31:0] sh_q, sh_d;
   logic [23:0] rb_q, rb_d;
   logic sdo_q, sdo_d, done_q, done_d;
   logic [23:0] fdat_q, fdat_d;
   logic [15:0] code_in_q, code_in_d;
   logic pend_q, pend_d;
   logic fall, rise, sync_rise, ld_fall;
   logic [5:0] need;

   assign fall = sclk_q & ~sclk;
   assign rise = ~sclk_q & sclk;
   assign sync_rise = ~fs_q & frame_sync_n;
   assign ld_fall = ld_q & ~load_dac_n;
   assign need = crc_en ? 6'(FRAME_BITS_CRC) : 6'(FRAME_BITS);

   // Bits are taken on falling edges; readback moves on rising edges.
   always_comb begin
      sclk_d = sclk;
      fs_d = frame_sync_n;
      ld_d = load_dac_n;
      cnt_d = cnt_q;
      sh_d = sh_q;
      rb_d = rb_q;
      sdo_d = sdo_q;
      done_d = 1'b0;
      fdat_d = fdat_q;
      code_in_d = code_in_q;
      pend_d = pend_q;
      // A code is offered to the held-strobe path once, so a later frame to
      // another register cannot replay an old code. A new write below wins.
      if (done_q) begin
         pend_d = 1'b0;
      end
      if (fs_q && !frame_sync_n) begin
         cnt_d = 6'h00;
         rb_d = autostatus_en ? status_word : 24'h000000;
      end
      if (!frame_sync_n && fall && cnt_q < need) begin
         sh_d = {sh_q[30:0], sdi};
         cnt_d = cnt_q + 6'h01;
      end
      if (!frame_sync_n && rise) begin
         sdo_d = (cnt_q < 6'(FRAME_BITS)) ? rb_q[23] : 1'b0;
         rb_d = {rb_q[22:0], 1'b0};
      end
      if (frame_sync_n) begin
         sdo_d = 1'b0;
      end
      // A short frame is dropped; only a full count is accepted.
      if (sync_rise && cnt_q == need) begin
         done_d = 1'b1;
         fdat_d = crc_en ? sh_q[31:8] : sh_q[23:0];
         if (fdat_d[23:16] == DAC_CODE_ADDR) begin
            code_in_d = fdat_d[15:0];
            pend_d = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sclk_q <= 1'b0;
         fs_q <= 1'b1;
         ld_q <= 1'b1;
         cnt_q <= 6'h00;
         sh_q <= 32'h00000000;
         rb_q <= 24'h000000;
         sdo_q <= 1'b0;
         done_q <= 1'b0;
         fdat_q <= 24'h000000;
         code_in_q <= CODE_RST;
         pend_q <= 1'b0;
      end else begin
         sclk_q <= sclk_d;
         fs_q <= fs_d;
         ld_q <= ld_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         rb_q <= rb_d;
         sdo_q <= sdo_d;
         done_q <= done_d;
         fdat_q <= fdat_d;
         code_in_q <= code_in_d;
         pend_q <= pend_d;
      end
   end

   // -----------------------------------------------------------------
   // Output update
   // -----------------------------------------------------------------
   logic [7:0] dly_q, dly_d;
   logic [15:0] out_q, out_d;
   logic upd_q, upd_d;
   logic busy_q, busy_d;
   logic [7:0] slew_wait;

   // Slew mode spends the longer budget, traded for a gentler core step.
   assign slew_wait = slew_en ? 8'(LOAD_SLEW_CYC - 2) : 8'(UPDATE_LAT_CYC);

   // A DAC code write with the strobe held low, or a strobe edge, starts the countdown.
   always_comb begin
      dly_d = dly_q;
      out_d = out_q;
      upd_d = 1'b0;
      busy_d = busy_q;
      if (busy_q) begin
         if (dly_q == 8'h00) begin
            out_d = code_in_q;
            upd_d = 1'b1;
            busy_d = 1'b0;
         end else begin
            dly_d = dly_q - 8'h01;
         end
      end else if (done_q && !load_dac_n && pend_q) begin
         busy_d = 1'b1;
         dly_d = 8'(UPDATE_LAT_CYC);
      end else if (ld_fall) begin
         busy_d = 1'b1;
         dly_d = slew_wait;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dly_q <= 8'h00;
         out_q <= CODE_RST;
         upd_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         dly_q <= dly_d;
         out_q <= out_d;
         upd_q <= upd_d;
         busy_q <= busy_d;
      end
   end

   assign sdo = sdo_q;
   assign dac_out = out_q;
   assign out_update = upd_q;
   assign frame_done = done_q;
   assign frame_data = fdat_q;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence s_ld_edge;
      $fell(load_dac_n) && !busy_q && !slew_en;
   endsequence

   sequence s_ld_slow;
      $fell(load_dac_n) && !busy_q && slew_en;
   endsequence

   chk_frame_len: assert property (@(posedge ref_clk) disable iff (!nrst)
      frame_done |-> $past(cnt_q) == need)
      else $error("frame accepted with wrong bit count");
   chk_sdo_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!frame_sync_n && rise && cnt_q >= 6'(FRAME_BITS)) |=> !sdo)
      else $error("surplus clock did not give zero");
   chk_sdo_rise: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!frame_sync_n && !fs_q && !rise) |=> $stable(sdo))
      else $error("readback bit moved off a rising edge");
   chk_sync_resp: assert property (@(posedge ref_clk) disable iff (!nrst)
      (done_q && !load_dac_n && pend_q && !busy_q) |-> ##[1:37] out_update)
      else $error("held strobe update too late");
   chk_ld_resp: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_ld_edge |-> ##[1:15] out_update)
      else $error("strobe update too late");
   chk_ld_slew: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_ld_slow |-> ##[1:50] out_update)
      else $error("slewed strobe update too late");

   // Frame acceptance, readback idle level and output code hold.
   chk_done_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
      frame_done |=> !frame_done)
      else $error("frame done longer than one cycle");
   chk_short_frame: assert property (@(posedge ref_clk) disable iff (!nrst)
      (sync_rise && cnt_q != need) |=> !frame_done)
      else $error("frame with wrong count accepted");
   chk_idle_sdo: assert property (@(posedge ref_clk) disable iff (!nrst)
      frame_sync_n |=> !sdo)
      else $error("readback output not low between frames");
   chk_code_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
      $changed(dac_out) |-> out_update)
      else $error("output code changed without update");
endmodule : dsf_frame
`default_nettype wire

/* File: design/dsf_pkg.sv */
/*
 File holds the constants of the serial frame timing block.
 Assumes a 25 MHz ref_clk and a host that samples serial data on falling clock edges.
*/
// Overview of operation
// - Frames are 24 bits, or 32 with CRC.
// - Surplus rising edges shift out zeros.
// - Strobe held low: update within 1.5 us.
// - Strobe edge: update within 600 ns/2 us.
// - Readback bit launched after rising edge.
`default_nettype none
package dsf_pkg;
   // -----------------------------------------------------------------
   // Frame layout
   // -----------------------------------------------------------------
   localparam int FRAME_BITS = 24;
   localparam int FRAME_BITS_CRC = 32;
   localparam logic [7:0] DAC_CODE_ADDR = 8'h01;
   localparam logic [7:0] OUT_CFG_ADDR = 8'h06;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int SYNC_RESP_NS = 1500;
   localparam int LOAD_FAST_NS = 600;
   localparam int LOAD_SLEW_NS = 2000;
   // Longest times round down.
   localparam int SYNC_RESP_CYC = SYNC_RESP_NS * CLK_MHZ / 1000;
   localparam int LOAD_FAST_CYC = LOAD_FAST_NS * CLK_MHZ / 1000;
   localparam int LOAD_SLEW_CYC = LOAD_SLEW_NS * CLK_MHZ / 1000;
   // Core answers after a short fixed pipeline, well inside every limit.
   localparam int UPDATE_LAT_CYC = 4;
   localparam logic [15:0] CODE_RST = 16'h0000;
endpackage : dsf_pkg
`default_nettype wire

/* File: verification/dsf_host.sv */
/*
 Host model: drives serial pins and load strobe.
 Assumes pins change just after a ref_clk rise.
*/
`default_nettype none
module dsf_host (
   input wire logic ref_clk,
   input wire logic sdo,
   output logic sclk,
   output logic frame_sync_n,
   output logic sdi,
   output logic load_dac_n
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk = 1'b0;
      frame_sync_n = 1'b1;
      sdi = 1'b0;
      load_dac_n = 1'b1;
   end
   // Data is not held between frames, so it toggles.
   always @(posedge ref_clk) if (frame_sync_n) sdi <= ~sdi;
   // Sends n bits MSB first; sdo is read before each fall.
   task automatic frame(input logic [31:0] w, input int n, output logic [31:0] rd);
      rd = 32'h0;
      frame_sync_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      for (int i = n - 1; i >= 0; i--) begin
         sdi <= w[i];
         sclk <= 1'b1;
         repeat (2) @(posedge ref_clk);
         @(negedge ref_clk);
         rd = {rd[30:0], sdo};
         @(posedge ref_clk);
         sclk <= 1'b0;
         repeat (3) @(posedge ref_clk);
      end
      frame_sync_n <= 1'b1;
   endtask : frame
   // Idle gap chosen by the register just written.
   task automatic gap(input logic [7:0] a);
      repeat (a == 8'h01 ? 38 : (a == 8'h06 ? 12500 : 13)) @(posedge ref_clk);
   endtask : gap
   // Strobe level held for cyc cycles.
   task automatic load(input logic lvl, input int cyc);
      load_dac_n <= lvl;
      repeat (cyc) @(posedge ref_clk);
   endtask : load
endmodule : dsf_host
`default_nettype wire

/* File: verification/dac_serial_frame_timing_tb_top.sv */
/*
 Self-checking bench of the frame block.
 Assumes the package and host model compile first.
*/
`default_nettype none
module dac_serial_frame_timing_tb_top import dsf_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic crc_en = 1'b0;
   logic slew_en = 1'b0;
   logic autostatus_en = 1'b1;
   logic [23:0] status_word = 24'h0;
   logic [15:0] lfsr_q = 16'h7BC8;
   logic [15:0] code;
   logic [31:0] rd;
   int error_cnt = 0;
   int tests_run = 0;
   int upd_cnt = 0;
   int done_cnt = 0;
   int n;
   wire logic sclk, frame_sync_n, sdi, load_dac_n, sdo, out_update, frame_done;
   wire logic [15:0] dac_out;
   wire logic [23:0] frame_data;
   dsf_host host (.ref_clk(ref_clk), .sdo(sdo), .sclk(sclk), .frame_sync_n(frame_sync_n),
      .sdi(sdi), .load_dac_n(load_dac_n));
   dsf_frame dut (.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .frame_sync_n(frame_sync_n),
      .sdi(sdi), .load_dac_n(load_dac_n), .crc_en(crc_en), .slew_en(slew_en),
      .autostatus_en(autostatus_en), .status_word(status_word), .sdo(sdo),
      .dac_out(dac_out), .out_update(out_update), .frame_done(frame_done),
      .frame_data(frame_data));
   // Clock and counts of output updates and accepted frames.
   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (out_update === 1'b1) upd_cnt++;
   always @(posedge ref_clk) if (frame_done === 1'b1) done_cnt++;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Readback: status MSB first, zeros on surplus edges.
   function automatic logic [31:0] exp_rb(input logic [23:0] s, input int bits);
      return {8'h0, s} << (bits - 24);
   endfunction : exp_rb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("errors=%0d checks=%0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   task automatic wait_upd(input int lim);
      for (int i = 0; i <= lim && out_update !== 1'b1; i++) @(negedge ref_clk);
      chk({out_update, 15'h0, dac_out}, {1'b1, 15'h0, code});
   endtask : wait_upd
   // One code write; lim of zero means the strobe does the update.
   task automatic wr(input logic [15:0] c, input int lim, input int bits);
      int d0;
      d0 = done_cnt;
      code = c;
      lfsr_q = lfsr(lfsr_q);
      status_word <= {lfsr_q, c[7:0]};
      @(posedge ref_clk);
      host.frame(bits == 32 ? {8'h01, c, lfsr_q[7:0]} : {8'h00, 8'h01, c}, bits, rd);
      if (lim > 0) wait_upd(lim);
      host.gap(bits == 28 ? 8'h00 : 8'h01);
      chk(done_cnt, d0 + 1);
      if (bits != 28) chk({8'h0, frame_data}, {16'h0001, c});
      if (bits != 32) chk(rd, exp_rb(status_word, bits));
   endtask : wr
   initial begin
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (2500) @(posedge ref_clk);
      host.load(1'b0, 1);
      for (int k = 0; k < 6; k++) begin
         crc_en <= k[0];
         lfsr_q = lfsr(lfsr_q);
         wr(k == 0 ? 16'hFFFF : (k == 5 ? 16'h0000 : lfsr_q), SYNC_RESP_CYC, k[0] ? 32 : 24);
      end
      crc_en <= 1'b0;
      host.load(1'b1, 1);
      wr(lfsr_q, 0, 28);
      for (int s = 0; s < 2; s++) begin
         slew_en <= s[0];
         n = upd_cnt;
         wr(lfsr(lfsr_q), 0, 24);
         chk(upd_cnt, n);
         host.load(1'b0, 0);
         wait_upd(s == 1 ? LOAD_SLEW_CYC : LOAD_FAST_CYC);
         repeat (7) @(posedge ref_clk);
         host.load(1'b1, 1);
      end
      summarize();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      summarize();
   end
endmodule : dac_serial_frame_timing_tb_top
`default_nettype wire
